// *** src/irq_enable_pkg.sv ***
// ==========================================================================
// register map and field layout of the interrupt enable mask
package irq_enable_pkg;
  localparam logic [7:0] IEM_ADDR          = 8'hA8;
  localparam logic [7:0] IEM_RESET         = 8'h00;
  localparam int         GLOBAL_EN_BIT     = 7;
  localparam int         SPI_EN_BIT        = 6;
  localparam int         TIMER_TWO_EN_BIT  = 5;
  localparam int         SERIAL_EN_BIT     = 4;
  localparam int         TIMER_ONE_EN_BIT  = 3;
  localparam int         EXT_ONE_EN_BIT    = 2;
  localparam int         TIMER_ZERO_EN_BIT = 1;
  localparam int         EXT_ZERO_EN_BIT   = 0;
  localparam int         NUM_SOURCES       = 7;
  // bit address base of a bit-addressable register equals its byte address
  localparam logic [4:0] IEM_BIT_BASE      = 5'h15;
  // values the read port and request flops take in reset and when idle
  localparam logic [7:0] RDATA_IDLE        = 8'h00;
  localparam logic [6:0] GATED_RESET       = 7'h00;
endpackage : irq_enable_pkg

// *** src/interrupt_enable_mask.sv ***
// How it works
// (R1) cleared global enable blocks every source request
// (R2) set global enable passes a request only when its own enable is set
// (R3) bits high to low: global, spi, timer2, serial, timer1, ext1, timer0, ext0
// (R4) timer two enable gates both low and high byte overflow flags
// (R5) serial port enable bit masks the serial port request
// (R6) external input one enable gates the external input one request
// (R7) register at address A8, every page, byte and bit access
// (R8) enable gating applies even when the pending flag is read-only
// (R9) gated requests are sampled and presented once every clock cycle
// (R10) timer0, timer1, ext0 enables gate only their own source
`timescale 1ns/1ns
`default_nettype none
module interrupt_enable_mask (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       BIT_WR,
  input  wire logic [7:0] BIT_ADDR,
  input  wire logic       BIT_VALUE,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       EXT_ZERO_PENDING,
  input  wire logic       TIMER_ZERO_OVERFLOW_FLAG,
  input  wire logic       EXT_IRQ_INPUT_ONE,
  input  wire logic       TIMER_ONE_OVERFLOW_FLAG,
  input  wire logic       SERIAL_PORT_PENDING,
  input  wire logic       TIMER_TWO_LOW_OVERFLOW_FLAG,
  input  wire logic       TIMER_TWO_HIGH_OVERFLOW_FLAG,
  input  wire logic       SPI_PORT_PENDING,
  output logic      [irq_enable_pkg::NUM_SOURCES-1:0] GATED_REQ
);
  import irq_enable_pkg::*;

  // ========================================================================
  // enable register
  logic [7:0] interrupt_enable_mask_reg;
  logic [7:0] next_mask;
  logic       bit_hit;
  logic       byte_hit;

  // decode byte and bit access, page select ignored
  assign byte_hit = SFR_WR && (SFR_ADDR == IEM_ADDR);                 // R7
  assign bit_hit  = BIT_WR && (BIT_ADDR[7:3] == IEM_BIT_BASE);        // R7

  // next value takes a byte write over a single bit write in the same cycle
  always_comb begin
    next_mask = interrupt_enable_mask_reg;
    if (byte_hit) begin
      next_mask = SFR_WDATA;                                          // R7
    end else if (bit_hit) begin
      next_mask[BIT_ADDR[2:0]] = BIT_VALUE;                           // R7
    end
  end

  // register update
  always_ff @(posedge CLK) begin
    if (RST) begin
      interrupt_enable_mask_reg <= IEM_RESET;
    end else begin
      interrupt_enable_mask_reg <= next_mask;
    end
  end

  // read back the whole byte at its address
  always_ff @(posedge CLK) begin
    if (RST) begin
      SFR_RDATA <= RDATA_IDLE;
    end else if (SFR_ADDR == IEM_ADDR) begin
      SFR_RDATA <= interrupt_enable_mask_reg;                         // R7
    end else begin
      SFR_RDATA <= RDATA_IDLE;
    end
  end

  // ========================================================================
  // gating
  logic       global_irq_enable;
  logic [6:0] raw_req;
  logic [6:0] src_enable;

  assign global_irq_enable = interrupt_enable_mask_reg[GLOBAL_EN_BIT];  // R3

  // sources in bit order ext0, t0, ext1, t1, serial, t2, spi
  assign raw_req = {SPI_PORT_PENDING,
                    TIMER_TWO_LOW_OVERFLOW_FLAG |
                    TIMER_TWO_HIGH_OVERFLOW_FLAG,                      // R4
                    SERIAL_PORT_PENDING,                               // R5
                    TIMER_ONE_OVERFLOW_FLAG,
                    EXT_IRQ_INPUT_ONE,                                 // R6
                    TIMER_ZERO_OVERFLOW_FLAG,
                    EXT_ZERO_PENDING};
  assign src_enable = {interrupt_enable_mask_reg[SPI_EN_BIT],
                       interrupt_enable_mask_reg[TIMER_TWO_EN_BIT],
                       interrupt_enable_mask_reg[SERIAL_EN_BIT],
                       interrupt_enable_mask_reg[TIMER_ONE_EN_BIT],
                       interrupt_enable_mask_reg[EXT_ONE_EN_BIT],
                       interrupt_enable_mask_reg[TIMER_ZERO_EN_BIT],
                       interrupt_enable_mask_reg[EXT_ZERO_EN_BIT]};    // R3

  // sampled every cycle, flags need not be clearable
  always_ff @(posedge CLK) begin
    if (RST) begin
      GATED_REQ <= GATED_RESET;
    end else begin
      GATED_REQ <= raw_req & src_enable                     // R2 R8 R10
                   & {NUM_SOURCES{global_irq_enable}};      // R1 R9
    end
  end

  // ========================================================================
  // checks
  logic [2:0] bit_sel;
  logic [6:0] own_enables;

  // bit index of a single bit write, held for the bit write check
  assign bit_sel     = BIT_ADDR[2:0];
  // source enables in register order, for the layout check
  assign own_enables = interrupt_enable_mask_reg[GLOBAL_EN_BIT-1:0];

  // global enable clear in the cycle that feeds the output flops
  sequence s_global_off;
    !global_irq_enable;
  endsequence

  // global enable set in the cycle that feeds the output flops
  sequence s_global_on;
    global_irq_enable;
  endsequence

  // one source armed: global on, own enable set, pending level high
  sequence s_source_armed(logic en, logic pend);
    global_irq_enable && en && pend;
  endsequence

  // byte write accepted at the register address
  sequence s_byte_write;
    byte_hit;
  endsequence

  // single bit write accepted with no byte write beside it
  sequence s_bit_write;
    bit_hit && !byte_hit;
  endsequence

  // register address presented for a read
  sequence s_read_addr;
    SFR_ADDR == IEM_ADDR;
  endsequence

  // global enable overrides every source
  a_global_blocks_all: assert property ( // R1
    @(posedge CLK) disable iff (RST)
    s_global_off |=> GATED_REQ == 7'h00)
    else $error("request passed while global enable clear");

  // with global set each output follows its own register bit
  a_source_passes: assert property ( // R2
    @(posedge CLK) disable iff (RST)
    s_global_on |=> GATED_REQ == ($past(raw_req) & $past(own_enables)))
    else $error("gated request mismatch");

  // spi request passes when global and spi enables are set
  a_spi_passes: assert property ( // R2 R3
    @(posedge CLK) disable iff (RST)
    s_source_armed(interrupt_enable_mask_reg[SPI_EN_BIT],
                   SPI_PORT_PENDING)
    |=> GATED_REQ[SPI_EN_BIT])
    else $error("spi request lost");

  // timer two low or high overflow raises the one timer two request
  a_timer_two_either: assert property ( // R4
    @(posedge CLK) disable iff (RST)
    s_source_armed(interrupt_enable_mask_reg[TIMER_TWO_EN_BIT],
                   TIMER_TWO_LOW_OVERFLOW_FLAG ||
                   TIMER_TWO_HIGH_OVERFLOW_FLAG)
    |=> GATED_REQ[TIMER_TWO_EN_BIT])
    else $error("timer two request lost");

  // serial enable clear blocks the serial request
  a_serial_mask: assert property ( // R5
    @(posedge CLK) disable iff (RST)
    !interrupt_enable_mask_reg[SERIAL_EN_BIT]
    |=> !GATED_REQ[SERIAL_EN_BIT])
    else $error("serial request not masked");

  // serial enable set lets a pending serial request through
  a_serial_passes: assert property ( // R5
    @(posedge CLK) disable iff (RST)
    s_source_armed(interrupt_enable_mask_reg[SERIAL_EN_BIT],
                   SERIAL_PORT_PENDING)
    |=> GATED_REQ[SERIAL_EN_BIT])
    else $error("serial request lost");

  // external one enable clear blocks the external one request
  a_ext_one_mask: assert property ( // R6
    @(posedge CLK) disable iff (RST)
    !interrupt_enable_mask_reg[EXT_ONE_EN_BIT]
    |=> !GATED_REQ[EXT_ONE_EN_BIT])
    else $error("external one request not masked");

  // external one enable set lets its input request through
  a_ext_one_passes: assert property ( // R6
    @(posedge CLK) disable iff (RST)
    s_source_armed(interrupt_enable_mask_reg[EXT_ONE_EN_BIT],
                   EXT_IRQ_INPUT_ONE)
    |=> GATED_REQ[EXT_ONE_EN_BIT])
    else $error("external one request lost");

  // timer one enable set lets its overflow request through
  a_timer_one_passes: assert property ( // R10
    @(posedge CLK) disable iff (RST)
    s_source_armed(interrupt_enable_mask_reg[TIMER_ONE_EN_BIT],
                   TIMER_ONE_OVERFLOW_FLAG)
    |=> GATED_REQ[TIMER_ONE_EN_BIT])
    else $error("timer one request lost");

  // an enabled external zero pending level shows on the very next edge
  a_latch_pending: assert property ( // R8 R9 R10
    @(posedge CLK) disable iff (RST)
    s_source_armed(interrupt_enable_mask_reg[EXT_ZERO_EN_BIT],
                   EXT_ZERO_PENDING)
    |=> GATED_REQ[EXT_ZERO_EN_BIT])
    else $error("enabled request not presented next cycle");

  // timer zero enable clear blocks the timer zero request
  a_timer_own_only: assert property ( // R10
    @(posedge CLK) disable iff (RST)
    !interrupt_enable_mask_reg[TIMER_ZERO_EN_BIT]
    |=> !GATED_REQ[TIMER_ZERO_EN_BIT])
    else $error("timer zero request not masked");

  // timer zero request comes only from its own flag
  a_timer_zero_alone: assert property ( // R10
    @(posedge CLK) disable iff (RST)
    !TIMER_ZERO_OVERFLOW_FLAG |=> !GATED_REQ[TIMER_ZERO_EN_BIT])
    else $error("timer zero request without its flag");

  // a byte write stores the whole byte
  a_byte_write: assert property ( // R7
    @(posedge CLK) disable iff (RST)
    s_byte_write |=> interrupt_enable_mask_reg == $past(SFR_WDATA))
    else $error("byte write not stored");

  // a bit write stores its value at the addressed bit
  a_bit_write: assert property ( // R7
    @(posedge CLK) disable iff (RST)
    s_bit_write |=>
    interrupt_enable_mask_reg[$past(bit_sel)] == $past(BIT_VALUE))
    else $error("bit write not stored");

  // a bit write leaves the other seven bits alone
  a_bit_others: assert property ( // R7
    @(posedge CLK) disable iff (RST)
    s_bit_write |=>
    (((interrupt_enable_mask_reg ^ $past(interrupt_enable_mask_reg))
      & ~(8'h01 << $past(bit_sel))) == 8'h00))
    else $error("bit write disturbed other bits");

  // the register holds when no write reaches it
  a_write_ignored: assert property ( // R7
    @(posedge CLK) disable iff (RST)
    (!byte_hit && !bit_hit) |=> $stable(interrupt_enable_mask_reg))
    else $error("register changed without a write");

  // the register address reads back the register one cycle later
  a_read_back: assert property ( // R7
    @(posedge CLK) disable iff (RST)
    s_read_addr |=> SFR_RDATA == $past(interrupt_enable_mask_reg))
    else $error("read data mismatch");

  // any other address reads as zero
  a_read_other: assert property ( // R7
    @(posedge CLK) disable iff (RST)
    (SFR_ADDR != IEM_ADDR) |=> SFR_RDATA == RDATA_IDLE)
    else $error("read data not idle at other address");
endmodule : interrupt_enable_mask
`default_nettype wire

// *** dv/pending_flags.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// peripheral pending flags seen by the mask
module pending_flags (
  input  wire logic       clk,
  input  wire logic [7:0] pattern,
  output logic      [7:0] flags = 8'h00
);
  // launch flag levels away from the sampling edge
  always @(negedge clk) flags <= pattern;
endmodule : pending_flags
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// bench for the interrupt enable mask
module tb;
  import irq_enable_pkg::*;
  logic       clk = 0, rst = 1, sfr_wr = 0, bit_wr = 0, bit_value = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic [7:0] pattern = 8'hFF, flags, rdata, mask = 8'h00, v;
  logic [NUM_SOURCES-1:0] gated;
  logic [15:0] corner [4] = '{16'h7FFF, 16'h80FF, 16'hA040, 16'hA020};
  int error_cnt = 0, tests_run = 0, cycles = 0, seed = 26;
  always #4 clk = ~clk;
  pending_flags u_pending_flags (.clk(clk), .pattern(pattern), .flags(flags));
  interrupt_enable_mask u_interrupt_enable_mask (.CLK(clk), .RST(rst),
    .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata),
    .BIT_WR(bit_wr), .BIT_ADDR(bit_addr), .BIT_VALUE(bit_value),
    .SFR_RDATA(rdata), .EXT_ZERO_PENDING(flags[0]),
    .TIMER_ZERO_OVERFLOW_FLAG(flags[1]), .EXT_IRQ_INPUT_ONE(flags[2]),
    .TIMER_ONE_OVERFLOW_FLAG(flags[3]), .SERIAL_PORT_PENDING(flags[4]),
    .TIMER_TWO_LOW_OVERFLOW_FLAG(flags[5]),
    .TIMER_TWO_HIGH_OVERFLOW_FLAG(flags[6]), .SPI_PORT_PENDING(flags[7]),
    .GATED_REQ(gated));
  // expected requests: timer two flags merged, global bit over all
  function automatic logic [6:0] want(logic [7:0] m, logic [7:0] p);
    return {p[7], p[6] | p[5], p[4:0]} & m[6:0] & {7{m[GLOBAL_EN_BIT]}};
  endfunction : want
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one byte or bit write, strobe high for a single edge
  task automatic wr(logic byte_w, logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_wr = byte_w;
    bit_wr = ~byte_w;
    sfr_addr = a;
    bit_addr = a;
    sfr_wdata = d;
    bit_value = d[0];
    @(negedge clk);
    sfr_wr = 0;
    bit_wr = 0;
  endtask : wr
  // read back an address and compare gated requests
  task automatic look(logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    chk("rdata", exp, rdata);
    chk("gated", {1'h0, want(mask, pattern)}, {1'h0, gated});
  endtask : look
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // cycle ceiling against a hang
  always @(posedge clk) if (++cycles > 4000) begin
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    look(IEM_ADDR, IEM_RESET);
    for (int i = 0; i < 4; i++) begin
      {mask, pattern} = corner[i];
      wr(1, IEM_ADDR, mask);
      look(IEM_ADDR, mask);
    end
    for (int i = 0; i < 60; i++) begin
      pattern = $random(seed);
      mask = $random(seed);
      wr(1, IEM_ADDR, mask);
      look(IEM_ADDR, mask);
    end
    for (int b = 0; b < 8; b++) begin
      v = $random(seed);
      mask[b] = v[0];
      wr(0, IEM_ADDR + 8'(b), v);
      look(IEM_ADDR, mask);
    end
    wr(1, 8'hA9, ~mask);
    wr(0, 8'hA7, ~mask);
    look(8'hA9, 8'h00);
    look(IEM_ADDR, mask);
    // mid-run reset brings the register back to its reset value
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    mask = IEM_RESET;
    look(IEM_ADDR, IEM_RESET);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
